// >>> bench/fsid_host_model.sv
// Host side of the three-wire link: captures bit-stream bytes and clocks
// the buffered register out with a 160 ns shift clock.
// Assumes the bench resolves the shared shift clock pin and feeds it back.
`timescale 1ns/1ps
`default_nettype none
module fsid_host_model (
  // Clock and mode
  input wire logic clk_in,
  input wire logic mode_in,
  input wire logic read_en_in,
  // Link
  input wire logic sclk_line_in,
  input wire logic data_in,
  input wire logic strobe_n_in,
  output logic sclk_out,
  // Captured results
  output logic [7:0] word_out,
  output logic [7:0] pulses_out,
  output logic stop_out,
  output logic [8:0] buf_out
);
  logic [7:0] sh;
  logic prev_sclk;
  logic prev_strobe;

  initial begin
    sclk_out = 1'b0;
    sh = 8'h00;
    word_out = 8'h00;
    pulses_out = 8'h00;
    stop_out = 1'b0;
    buf_out = 9'h000;
    prev_sclk = 1'b1;
    prev_strobe = 1'b1;
  end

  // ==========================================
  // Bit-stream capture, polled on the system clock
  always @(posedge clk_in) begin
    if (!mode_in && sclk_line_in && !prev_sclk) begin
      sh <= {data_in, sh[7:1]};
      pulses_out <= pulses_out + 8'h01;
    end
    if (!mode_in && !strobe_n_in && prev_strobe) begin
      word_out <= sh;
    end
    if (!mode_in && strobe_n_in && !prev_strobe) begin
      stop_out <= data_in;
    end
    prev_sclk <= sclk_line_in;
    prev_strobe <= strobe_n_in;
  end

  // ==========================================
  // Buffered read-out; clock stands low outside a read
  always begin
    @(negedge strobe_n_in);
    if (mode_in && read_en_in) begin
      // Odd offset keeps the link clock out of phase with the system clock
      #83;
      repeat (9) begin
        sclk_out = 1'b1;
        #80;
        buf_out = {data_in, buf_out[8:1]};
        sclk_out = 1'b0;
        #80;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench of the FSK serial data interface.
// Assumes shortened bit and carrier counts set through the top parameters.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fsid_pkg::*;
  localparam int BIT = 64;
  localparam int HALF = 32;
  localparam int QUAL = 50;
  localparam int REL = 400;
  logic mclk_in = 1'b0;
  logic arst_n_in;
  logic [3:0] avs_address_in;
  logic avs_read_in;
  logic avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic demod_bit_in;
  logic energy_in;
  logic ring_in;
  logic tone_detect_n_in;
  logic interface_mode_select_in;
  logic shift_clock_line_out;
  logic shift_clock_line_oe_out;
  logic data_out;
  logic shared_strobe_n_out;
  logic carrier_present_n_out;
  logic tone_estimate_out;
  logic guard_time_node_out;
  logic host_sclk;
  logic sclk_line;
  logic host_read_en;
  logic [7:0] host_word;
  logic [7:0] host_pulses;
  logic host_stop;
  logic [8:0] host_buf;
  logic [31:0] rd;
  logic [7:0] p0;
  int n_errors = 0;
  int tests_run = 0;
  int low_run = 0;
  int last_low = 0;
  int n_falls = 0;
  int f0;

  always #5 mclk_in = ~mclk_in;
  // Pin level: device drives it while enabled, otherwise the host
  assign sclk_line = shift_clock_line_oe_out ? shift_clock_line_out : host_sclk;

  fsid_top #(.BIT_CYC_P(BIT), .HALF_CYC_P(HALF), .QUAL_CYC_P(QUAL), .REL_CYC_P(REL))
    fsid_top_inst (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .demod_bit_in(demod_bit_in), .energy_in(energy_in), .ring_in(ring_in),
    .tone_detect_n_in(tone_detect_n_in),
    .interface_mode_select_in(interface_mode_select_in),
    .shift_clock_line_in(sclk_line), .shift_clock_line_out(shift_clock_line_out),
    .shift_clock_line_oe_out(shift_clock_line_oe_out), .data_out(data_out),
    .shared_strobe_n_out(shared_strobe_n_out),
    .carrier_present_n_out(carrier_present_n_out),
    .tone_estimate_out(tone_estimate_out), .guard_time_node_out(guard_time_node_out));

  fsid_host_model fsid_host_model_inst (.clk_in(mclk_in),
    .mode_in(interface_mode_select_in), .read_en_in(host_read_en),
    .sclk_line_in(sclk_line), .data_in(data_out), .strobe_n_in(shared_strobe_n_out),
    .sclk_out(host_sclk), .word_out(host_word), .pulses_out(host_pulses),
    .stop_out(host_stop), .buf_out(host_buf));

  // ==========================================
  // Strobe monitor: number of falls and length of the last low spell
  always @(posedge mclk_in) begin
    if (shared_strobe_n_out === 1'b0) begin
      if (low_run == 0) n_falls++;
      low_run++;
    end else if (low_run != 0) begin
      last_low = low_run;
      low_run = 0;
    end
  end

  // ==========================================
  // Checks and bus access
  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                          output logic [31:0] d);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    @(posedge mclk_in);
    while (avs_waitrequest_out !== 1'b0) begin
      @(posedge mclk_in);
      n++;
    end
    chk_word("wait states", 32'h1, n);
    d = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge mclk_in);
  endtask

  // One character: start, eight data bits first bit lowest, stop, idle mark
  task automatic send_byte(input logic [7:0] b, input logic stop);
    demod_bit_in <= 1'b0;
    repeat (BIT) @(posedge mclk_in);
    for (int i = 0; i < 8; i++) begin
      demod_bit_in <= b[i];
      repeat (BIT) @(posedge mclk_in);
    end
    demod_bit_in <= stop;
    repeat (BIT) @(posedge mclk_in);
    demod_bit_in <= 1'b1;
    repeat (3 * BIT) @(posedge mclk_in);
  endtask

  // ==========================================
  // Test sequence
  initial begin
    arst_n_in = 1'b0;
    avs_address_in = 4'h0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    demod_bit_in = 1'b1;
    energy_in = 1'b0;
    ring_in = 1'b0;
    tone_detect_n_in = 1'b1;
    interface_mode_select_in = 1'b0;
    host_read_en = 1'b1;
    repeat (10) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    repeat (5) @(posedge mclk_in);
    bus_xfer(1'b0, CTRL_ADDR, 32'h0, rd);
    chk_word("ctrl reset", {30'h0, CTRL_RESET}, rd);
    bus_xfer(1'b1, 4'hC, 32'hFFFF_FFFF, rd);
    bus_xfer(1'b0, 4'hC, 32'h0, rd);
    chk_word("unmapped read", 32'h0, rd);
    bus_xfer(1'b0, CTRL_ADDR, 32'h0, rd);
    chk_word("ctrl kept", {30'h0, CTRL_RESET}, rd);
    ring_in <= 1'b1;
    energy_in <= 1'b1;
    repeat (2 * QUAL) @(posedge mclk_in);
    chk_bit("carrier under ringing", 1'b1, carrier_present_n_out);
    ring_in <= 1'b0;
    repeat (QUAL + 10) @(posedge mclk_in);
    chk_bit("carrier qualified", 1'b0, carrier_present_n_out);
    p0 = host_pulses;
    f0 = n_falls;
    send_byte(8'hA5, 1'b1);
    chk_word("pulse count", 32'h8, {24'h0, 8'(host_pulses - p0)});
    chk_word("stream byte", 32'hA5, {24'h0, host_word});
    chk_bit("stream stop", 1'b1, host_stop);
    chk_word("ready low time", HALF, last_low);
    chk_word("ready falls", 32'h1, n_falls - f0);
    send_byte(8'h5A, 1'b0);
    chk_word("stream byte 2", 32'h5A, {24'h0, host_word});
    chk_bit("stream bad stop", 1'b0, host_stop);
    interface_mode_select_in <= 1'b1;
    repeat (20) @(posedge mclk_in);
    send_byte(8'h3C, 1'b0);
    chk_word("buffered word", 32'h03C, {23'h0, host_buf});
    chk_bit("ready cleared by edge", 1'b1, last_low < HALF);
    bus_xfer(1'b0, STATUS_ADDR, 32'h0, rd);
    chk_word("status byte", 32'h03C, {23'h0, rd[16:8]});
    chk_bit("framing flag", 1'b1, rd[ST_FERR_BIT]);
    chk_bit("status carrier", 1'b1, rd[ST_CD_BIT]);
    chk_bit("status ready", 1'b0, rd[ST_READY_BIT]);
    host_read_en <= 1'b0;
    send_byte(8'h81, 1'b1);
    chk_word("ready low unread", HALF, last_low);
    bus_xfer(1'b0, STATUS_ADDR, 32'h0, rd);
    chk_word("status byte 2", 32'h181, {23'h0, rd[16:8]});
    host_read_en <= 1'b1;
    energy_in <= 1'b0;
    repeat (REL - 20) @(posedge mclk_in);
    chk_bit("carrier through dropout", 1'b0, carrier_present_n_out);
    repeat (40) @(posedge mclk_in);
    chk_bit("carrier released", 1'b1, carrier_present_n_out);
    f0 = n_falls;
    send_byte(8'h55, 1'b1);
    chk_word("no load unqualified", f0, n_falls);
    interface_mode_select_in <= 1'b0;
    repeat (20) @(posedge mclk_in);
    p0 = host_pulses;
    demod_bit_in <= 1'b0;
    repeat (BIT / 2) @(posedge mclk_in);
    chk_bit("data forced high", 1'b1, data_out);
    chk_bit("clock forced high", 1'b1, shift_clock_line_out);
    send_byte(8'h00, 1'b0);
    chk_word("no pulses unqualified", 32'h0, {24'h0, 8'(host_pulses - p0)});
    chk_word("no ready unqualified", f0, n_falls);
    tone_detect_n_in <= 1'b0;
    bus_xfer(1'b1, CTRL_ADDR, 32'h0, rd);
    repeat (10) @(posedge mclk_in);
    chk_bit("tone on shared pin", 1'b0, shared_strobe_n_out);
    chk_bit("tone estimate", 1'b1, tone_estimate_out);
    bus_xfer(1'b1, CTRL_ADDR, 32'h2, rd);
    repeat (10) @(posedge mclk_in);
    chk_bit("pd strobe", 1'b1, shared_strobe_n_out);
    chk_bit("pd data", 1'b1, data_out);
    chk_bit("pd carrier", 1'b1, carrier_present_n_out);
    chk_bit("pd estimate", 1'b0, tone_estimate_out);
    chk_bit("pd guard node", 1'b0, guard_time_node_out);
    chk_bit("pd clock pin input", 1'b0, shift_clock_line_oe_out);
    end_of_test();
  end

  // Run takes about 5700 cycles; the limit leaves ample margin
  initial begin
    repeat (30000) @(posedge mclk_in);
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> design/fsid_carrier.sv
// Carrier qualifier: in-band energy held for a qualify time sets carrier,
// a quiet spell of the release time clears it. Energy during ringing does not count as in-band.
`timescale 1ns/1ps
`default_nettype none
module fsid_carrier #(
  parameter int QUAL_CYC = fsid_pkg::CD_QUALIFY_CYC,
  parameter int REL_CYC = fsid_pkg::CD_RELEASE_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Detector inputs and power-down gate, already synchronised
  input wire logic energy_in,
  input wire logic ring_in,
  input wire logic pd_in,
  // Qualified carrier
  output logic active_out
);
  import fsid_pkg::*;

  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_active, inband;

  always_comb begin
    inband = energy_in & ~ring_in; // see R17
    next_cnt = cnt;
    next_active = active_out;
    if (pd_in) begin
      next_cnt = '0;
      next_active = 1'b0;
    end else if (!active_out) begin
      // Qualification demands unbroken in-band energy, so any gap or ringing restarts it
      if (!inband) begin
        next_cnt = '0;
      end else if (cnt == CNT_W'(QUAL_CYC - 1)) begin
        next_cnt = '0;
        next_active = 1'b1; // see R14
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end else if (inband) begin
      next_cnt = '0;
    end else if (cnt == CNT_W'(REL_CYC - 1)) begin
      next_cnt = '0;
      next_active = 1'b0; // see R14
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      active_out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      active_out <= next_active;
    end
  end
endmodule
`default_nettype wire

// >>> design/fsid_pkg.sv
// Constants and types of the FSK serial data interface.
// Assumes a 100 MHz system clock and a 1200 baud asynchronous stream.
//
// Contract
// R1 - Static pin: low bit-stream, high buffered byte
// R2 - Timing built only for 1200 baud
// R3 - Bit-stream: raw bits on data, timing pins outputs
// R4 - Eight shift pulses, rising at data centres
// R5 - No shift pulses in start or stop
// R6 - Byte-ready low half bit from stop start
// R7 - Host may sample stop at byte-ready rise
// R8 - Polling host keeps last eight clocked bits
// R9 - Buffered: load nine bits mid stop, strobe low
// R10 - Host rising edges shift bits out in order
// R11 - Host shift clock low around strobe fall
// R12 - Strobe clears on first edge or half bit
// R13 - Eight host pulses, ninth reads stop bit
// R14 - Carrier qualified, released after 10 ms quiet
// R15 - No carrier: ignore demod, bit-stream outputs high
// R16 - No carrier, buffered: no reload, strobe high
// R17 - Ringing never qualifies carrier
// R18 - Host selects tones or power-down when idle
// R19 - Strobe pin shared with tone detect output
// R20 - Host ends message on listed conditions
// R21 - Power-down drives shared strobe high
// R22 - Power-down: outputs high, nodes low, clock input
// R23 - Bit timing counted from start edge
// R24 - Stop bit zero flags framing error
package fsid_pkg;
  // ==========================================
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD = 1200; // see R2
  localparam int HALF_BIT_HZ = 2400;
  localparam int CD_RELEASE_MS = 10;
  localparam int CD_QUALIFY_MS = 3;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int HALF_CYC = CLK_HZ / HALF_BIT_HZ;
  localparam int CD_RELEASE_CYC = CLK_HZ / 1000 * CD_RELEASE_MS;
  localparam int CD_QUALIFY_CYC = CLK_HZ / 1000 * CD_QUALIFY_MS;
  localparam int CNT_W = 20;
  // ==========================================
  // Register map (byte addresses)
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam int CTRL_FSK_BIT = 0;
  localparam int CTRL_PD_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int ST_CD_BIT = 0;
  localparam int ST_FERR_BIT = 1;
  localparam int ST_READY_BIT = 2;
  localparam int ST_BYTE_LSB = 8;
  // ==========================================
  // Types
  typedef enum logic [1:0] {FSID_IDLE, FSID_START, FSID_DATA, FSID_STOP} fsid_rx_t;
  typedef struct packed {
    logic data;
    logic sclk;
    logic sclk_oe;
    logic strobe_n;
    logic cd_n;
    logic estimate;
    logic gt;
  } fsid_pins_t;
endpackage

// >>> design/fsid_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous input; output moves once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module fsid_sync #(
  parameter logic INIT = 1'b1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Signal
  input wire logic d_in,
  output logic q_out
);
  logic s1, s2, s3, next_q;

  always_comb begin
    next_q = (s2 == s3) ? s3 : q_out;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q_out <= INIT;
    end else begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
      q_out <= next_q;
    end
  end
endmodule
`default_nettype wire

// >>> design/fsid_top.sv
// FSK serial data interface: bit recovery, bit-stream and buffered byte
// output, carrier gating, shared strobe pin and an Avalon-MM control port.
// Assumes asynchronous pins from the demodulator and the host.
`timescale 1ns/1ps
`default_nettype none
module fsid_top #(
  parameter int BIT_CYC_P = fsid_pkg::BIT_CYC,
  parameter int HALF_CYC_P = fsid_pkg::HALF_CYC,
  parameter int QUAL_CYC_P = fsid_pkg::CD_QUALIFY_CYC,
  parameter int REL_CYC_P = fsid_pkg::CD_RELEASE_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Demodulator and detectors
  input wire logic demod_bit_in,
  input wire logic energy_in,
  input wire logic ring_in,
  input wire logic tone_detect_n_in,
  // Host link
  input wire logic interface_mode_select_in,
  input wire logic shift_clock_line_in,
  output logic shift_clock_line_out,
  output logic shift_clock_line_oe_out,
  output logic data_out,
  output logic shared_strobe_n_out,
  output logic carrier_present_n_out,
  output logic tone_estimate_out,
  output logic guard_time_node_out
);
  import fsid_pkg::*;

  // ==========================================
  // Reset release
  logic rst_a, rst_n;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end

  // ==========================================
  // Input synchronisers
  logic demod, energy, ring, tone_n, mode_sel, host_clk, host_clk_q;
  logic [4:0] raw_in, sync_q;
  assign raw_in = {demod_bit_in, energy_in, ring_in, tone_detect_n_in, interface_mode_select_in};
  generate
    for (genvar i = 0; i < 5; i++) begin : g_sync
      fsid_sync #(.INIT(1'b1)) u_sync (
        .clk_in(mclk_in),
        .rst_n_in(rst_n),
        .d_in(raw_in[i]),
        .q_out(sync_q[i])
      );
    end
  endgenerate
  assign {demod, energy, ring, tone_n, mode_sel} = sync_q;
  fsid_sync #(.INIT(1'b0)) u_sclk_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .d_in(shift_clock_line_in),
    .q_out(host_clk)
  );

  // ==========================================
  // Control register and carrier
  logic [1:0] ctrl, next_ctrl;
  logic fsk_sel, pd, mode1, cd_act;
  assign fsk_sel = ctrl[CTRL_FSK_BIT];
  assign pd = ctrl[CTRL_PD_BIT];
  // Power-down forces buffered mode so the shift clock pin turns input
  assign mode1 = mode_sel | pd; // see R1 R22

  fsid_carrier #(.QUAL_CYC(QUAL_CYC_P), .REL_CYC(REL_CYC_P)) u_carrier (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .energy_in(energy),
    .ring_in(ring),
    .pd_in(pd | ~fsk_sel),
    .active_out(cd_act)
  );

  // ==========================================
  // Bit recovery
  fsid_rx_t st, next_st;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [3:0] idx, next_idx;
  logic [7:0] rx_byte, next_rx_byte;
  logic demod_q, sclk0, next_sclk0, dr0_n, next_dr0_n, stop_evt;

  always_comb begin
    next_st = st;
    next_cnt = cnt + 1'b1;
    next_idx = idx;
    next_rx_byte = rx_byte;
    next_sclk0 = sclk0;
    next_dr0_n = dr0_n;
    stop_evt = 1'b0;
    case (st)
      FSID_IDLE: begin
        next_cnt = '0;
        if (demod_q && !demod) begin
          next_st = FSID_START; // see R23
        end
      end
      FSID_START: begin
        if (cnt == CNT_W'(HALF_CYC_P - 1)) begin
          next_cnt = '0;
          next_idx = '0;
          next_st = demod ? FSID_IDLE : FSID_DATA;
        end
      end
      FSID_DATA: begin
        if (cnt == CNT_W'(HALF_CYC_P - 1)) begin
          next_sclk0 = 1'b0;
        end
        if (cnt == CNT_W'(BIT_CYC_P - 1)) begin
          // Centre of a data cell: sample and raise the shift clock
          next_cnt = '0;
          next_rx_byte = {demod, rx_byte[7:1]};
          next_sclk0 = 1'b1; // see R4
          next_idx = idx + 1'b1;
          if (idx == 4'h7) begin
            next_st = FSID_STOP;
          end
        end
      end
      FSID_STOP: begin
        if (cnt == CNT_W'(HALF_CYC_P - 1)) begin
          next_sclk0 = 1'b0; // see R5
          next_dr0_n = 1'b0; // see R6
        end
        if (cnt == CNT_W'(BIT_CYC_P - 1)) begin
          next_dr0_n = 1'b1;
          stop_evt = 1'b1; // see R9
          next_st = FSID_IDLE;
        end
      end
      default: next_st = FSID_IDLE;
    endcase
    if (!cd_act) begin
      // Demodulator output means nothing without carrier
      next_st = FSID_IDLE; // see R15
      next_sclk0 = 1'b0;
      next_dr0_n = 1'b1;
      stop_evt = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      st <= FSID_IDLE;
      cnt <= '0;
      idx <= '0;
      rx_byte <= '0;
      demod_q <= 1'b1;
      sclk0 <= 1'b0;
      dr0_n <= 1'b1;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      idx <= next_idx;
      rx_byte <= next_rx_byte;
      demod_q <= demod;
      sclk0 <= next_sclk0;
      dr0_n <= next_dr0_n;
    end
  end

  // ==========================================
  // Nine-bit output buffer
  logic [8:0] buf_q, next_buf, last_q, next_last;
  logic buf_bit, next_buf_bit, dr1_n, next_dr1_n, host_rise, load;
  logic [CNT_W-1:0] rdy_cnt, next_rdy_cnt;
  assign host_rise = host_clk & ~host_clk_q;
  assign load = stop_evt & fsk_sel & ~pd;

  always_comb begin
    next_buf = buf_q;
    next_buf_bit = buf_bit;
    next_dr1_n = dr1_n;
    next_rdy_cnt = rdy_cnt;
    next_last = last_q;
    if (mode1 && host_rise) begin
      next_buf_bit = buf_q[0]; // see R10 R13
      next_buf = {1'b0, buf_q[8:1]};
      next_dr1_n = 1'b1; // see R12
    end
    if (!dr1_n) begin
      next_rdy_cnt = rdy_cnt + 1'b1;
      if (rdy_cnt == CNT_W'(HALF_CYC_P - 1)) begin
        next_dr1_n = 1'b1; // see R12
      end
    end
    if (load) begin
      // Stop bit sits above the data so it leaves ninth
      next_last = {demod, rx_byte}; // see R24
      if (mode1) begin
        next_buf = {demod, rx_byte}; // see R9
        next_dr1_n = 1'b0;
        next_rdy_cnt = '0;
      end
    end
    if (!cd_act || !mode1) begin
      next_dr1_n = 1'b1; // see R16
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      buf_q <= '0;
      buf_bit <= 1'b1;
      dr1_n <= 1'b1;
      rdy_cnt <= '0;
      last_q <= '0;
      host_clk_q <= 1'b0;
    end else begin
      buf_q <= next_buf;
      buf_bit <= next_buf_bit;
      dr1_n <= next_dr1_n;
      rdy_cnt <= next_rdy_cnt;
      last_q <= next_last;
      host_clk_q <= host_clk;
    end
  end

  // ==========================================
  // Pin drive
  fsid_pins_t pins, next_pins;

  always_comb begin
    next_pins.estimate = ~tone_n & ~fsk_sel;
    next_pins.gt = ~tone_n & ~fsk_sel;
    next_pins.cd_n = ~cd_act;
    next_pins.sclk_oe = ~mode1; // see R3
    if (!mode1) begin
      next_pins.data = cd_act ? demod : 1'b1; // see R3 R15
      next_pins.sclk = cd_act ? sclk0 : 1'b1;
    end else begin
      next_pins.data = buf_bit;
      next_pins.sclk = 1'b0;
    end
    // Strobe pin carries byte-ready in FSK, tone detect otherwise
    if (fsk_sel) begin
      next_pins.strobe_n = mode1 ? dr1_n : dr0_n; // see R19
    end else begin
      next_pins.strobe_n = tone_n;
    end
    if (pd) begin
      next_pins.data = 1'b1; // see R22
      next_pins.strobe_n = 1'b1; // see R21
      next_pins.cd_n = 1'b1;
      next_pins.estimate = 1'b0;
      next_pins.gt = 1'b0;
      next_pins.sclk = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      pins <= '{data: 1'b1, sclk: 1'b0, sclk_oe: 1'b0, strobe_n: 1'b1,
                cd_n: 1'b1, estimate: 1'b0, gt: 1'b0};
    end else begin
      pins <= next_pins;
    end
  end

  assign data_out = pins.data;
  assign shift_clock_line_out = pins.sclk;
  assign shift_clock_line_oe_out = pins.sclk_oe;
  assign shared_strobe_n_out = pins.strobe_n;
  assign carrier_present_n_out = pins.cd_n;
  assign tone_estimate_out = pins.estimate;
  assign guard_time_node_out = pins.gt;

  // ==========================================
  // Avalon-MM slave: one wait state per access
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
  assign avs_readdata_out = rdata;

  always_comb begin
    next_ack = (avs_read_in | avs_write_in) & ~ack;
    next_ctrl = ctrl;
    next_rdata = rdata;
    if (avs_write_in && ack && avs_address_in == CTRL_ADDR) begin
      next_ctrl = avs_writedata_in[1:0];
    end
    if (avs_read_in && !ack) begin
      next_rdata = '0;
      if (avs_address_in == CTRL_ADDR) begin
        next_rdata[1:0] = ctrl;
      end else if (avs_address_in == STATUS_ADDR) begin
        next_rdata[ST_CD_BIT] = cd_act;
        next_rdata[ST_FERR_BIT] = ~last_q[8]; // see R24
        next_rdata[ST_READY_BIT] = ~pins.strobe_n & fsk_sel;
        next_rdata[ST_BYTE_LSB +: 9] = last_q;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      ctrl <= CTRL_RESET;
      rdata <= '0;
    end else begin
      ack <= next_ack;
      ctrl <= next_ctrl;
      rdata <= next_rdata;
    end
  end

  // ==========================================
  // Checks
  logic [CNT_W-1:0] drlow;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      drlow <= '0;
    end else begin
      drlow <= shared_strobe_n_out ? '0 : drlow + 1'b1;
    end
  end

  property p_pd_pins;
    @(posedge mclk_in) disable iff (!rst_n)
    pd |=> (data_out && shared_strobe_n_out && carrier_present_n_out && !tone_estimate_out);
  endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("power-down pins wrong"); // see R22
  property p_pd_oe;
    @(posedge mclk_in) disable iff (!rst_n) pd |=> !shift_clock_line_oe_out;
  endproperty
  a_pd_oe: assert property (p_pd_oe) else $error("shift clock driven in power-down"); // see R22
  property p_nocd_high;
    @(posedge mclk_in) disable iff (!rst_n)
    (!cd_act && !mode1 && !pd) |=> (data_out && shift_clock_line_out);
  endproperty
  a_nocd_high: assert property (p_nocd_high) else $error("outputs not high without carrier"); // see R15
  property p_nocd_noload;
    @(posedge mclk_in) disable iff (!rst_n) !cd_act |=> (dr0_n && dr1_n && $stable(last_q));
  endproperty
  a_nocd_noload: assert property (p_nocd_noload) else $error("buffer loaded without carrier"); // see R16
  property p_ready_short;
    @(posedge mclk_in) disable iff (!rst_n)
    fsk_sel |-> drlow <= CNT_W'(HALF_CYC_P + 1);
  endproperty
  a_ready_short: assert property (p_ready_short) else $error("byte ready low too long"); // see R6 R12
  property p_host_clear;
    @(posedge mclk_in) disable iff (!rst_n)
    (mode1 && host_rise && !load && fsk_sel && !pd) |=> ##1 shared_strobe_n_out;
  endproperty
  a_host_clear: assert property (p_host_clear) else $error("host edge left strobe low"); // see R12
  property p_load_dr;
    @(posedge mclk_in) disable iff (!rst_n)
    (load && mode1 && cd_act) |=> ##1 !shared_strobe_n_out;
  endproperty
  a_load_dr: assert property (p_load_dr) else $error("load did not lower strobe"); // see R9
  property p_no_sclk_stop;
    @(posedge mclk_in) disable iff (!rst_n)
    (st == FSID_STOP && cnt >= CNT_W'(HALF_CYC_P)) |-> !sclk0;
  endproperty
  a_no_sclk_stop: assert property (p_no_sclk_stop) else $error("shift clock in stop bit"); // see R5
  property p_eight;
    @(posedge mclk_in) disable iff (!rst_n)
    $rose(sclk0) |-> (idx >= 4'h1 && idx <= 4'h8 && st != FSID_IDLE && st != FSID_START);
  endproperty
  a_eight: assert property (p_eight) else $error("extra shift clock pulse"); // see R4
  c_byte0: cover property (@(posedge mclk_in) disable iff (!rst_n) !mode1 && $fell(dr0_n));
  c_byte1: cover property (@(posedge mclk_in) disable iff (!rst_n) load && mode1);
  c_hostclr: cover property (@(posedge mclk_in) disable iff (!rst_n) host_rise && !dr1_n);
endmodule
`default_nettype wire
